/* File: hdl/dcc_top.sv */
/*
  dcc_top: control and configuration registers of the dc-dc boost converter,
  plus converter tick generation and ADC tracking/SAR-clock synchronisation.
  Assumes the CPU presents SFR page, address, write strobe and read strobe on clk_i.
*/
// Summary of operation
// - the minimum pulse width code 00/01/10/11 means none, 20 ns, 40 ns, 80 ns.
// - switch size select 0 picks the large switches and 1 the small ones.
// - with synchronisation off the ADC runs free of the switching cycle.
// - with synchronisation on ADC tracking is confined to the longest quiet interval.
// - with synchronisation on the SAR clock is derived from the switching cycle.
// - the synchronisation behaviour applies to the later silicon revision.
// - the voltage code 000 to 111 selects 1.8 to 3.3 V targets.
// - the control register decodes at address 0x97 on page 0x0.
// - the configuration register decodes at address 0x96 on page 0x0.
// - the clock divider divides the system clock by 1, 2, 4 or 8.
// - the clock source bit picks the local oscillator at 0, system clock at 1.
// - the sleep bit ties the output rail to battery at 0 and floats it at 1.
// - with synchronisation on the ADC clock inversion bit inverts the SAR clock at 0, not at 1.
`timescale 1ns/1ps
module dcc_top (
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic srst_i, // sync reset, active high
  input wire logic [7:0] sfr_page_i, // register page
  input wire logic [7:0] sfr_addr_i, // register address
  input wire logic [7:0] sfr_wdata_i, // write data
  input wire logic sfr_wr_i, // write strobe
  input wire logic sfr_rd_i, // read strobe
  output logic [7:0] sfr_rdata_o, // read data
  output logic sfr_hit_o, // address decodes here
  output logic [1:0] min_pulse_width_o, // pulse width code
  output logic [7:0] min_pulse_cycles_o, // pulse width in clocks
  output logic switch_size_select_o, // 1 small switches
  output logic [2:0] output_voltage_select_o, // target code
  output logic [11:0] target_mv_o, // target in mV
  output logic converter_clock_source_o, // 1 system clock
  output logic converter_tick_o, // converter clock enable
  output logic converter_clock_invert_o, // invert divider input
  output logic peak_current_threshold_o, // 1 higher peak limit
  output logic sleep_rail_connection_o, // 1 float in sleep
  output logic adc_sync_o, // synchronisation enabled
  output logic adc_track_allow_o, // ADC may track
  output logic adc_sar_clk_o // SAR clock level
);
  // ==========================================================
  // register file
  logic [7:0] converter_control;
  logic [7:0] converter_config;
  logic [7:0] next_control;
  logic [7:0] next_config;
  logic page_ok;
  logic ctl_sel;
  logic cfg_sel;

  always_comb begin
    page_ok = (sfr_page_i == dcc_pkg::DCC_PAGE);
    ctl_sel = page_ok && (sfr_addr_i == dcc_pkg::DCC_CONTROL_ADDR);
    cfg_sel = page_ok && (sfr_addr_i == dcc_pkg::DCC_CONFIG_ADDR);
    next_control = converter_control;
    next_config = converter_config;
    if (sfr_wr_i && ctl_sel) begin
      next_control = sfr_wdata_i;
      next_control[dcc_pkg::DCC_RSVD_BIT] = 1'b0;
    end
    if (sfr_wr_i && cfg_sel) begin
      next_config = {1'b0, sfr_wdata_i[6:0]}; // bit 7 reads zero
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      converter_control <= dcc_pkg::DCC_CONTROL_RST;
      converter_config <= dcc_pkg::DCC_CONFIG_RST;
    end else begin
      converter_control <= next_control;
      converter_config <= next_config;
    end
  end

  // read data is registered; valid the cycle after the read strobe
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_rd_i && ctl_sel) begin
      next_rdata = converter_control;
    end else if (sfr_rd_i && cfg_sel) begin
      next_rdata = converter_config;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

  assign sfr_hit_o = ctl_sel || cfg_sel;

  // ==========================================================
  // field decode
  logic sync_en;
  always_comb begin
    min_pulse_width_o = converter_control[dcc_pkg::DCC_PULSE_LSB +: 2];
    switch_size_select_o = converter_control[dcc_pkg::DCC_SWSZ_BIT];
    output_voltage_select_o = converter_control[dcc_pkg::DCC_VOUT_LSB +: 3];
    sync_en = converter_control[dcc_pkg::DCC_SYNC_BIT];
    converter_clock_source_o = converter_config[dcc_pkg::DCC_CSRC_BIT];
    converter_clock_invert_o = converter_config[dcc_pkg::DCC_CINV_BIT];
    peak_current_threshold_o = converter_config[dcc_pkg::DCC_ILIM_BIT];
    sleep_rail_connection_o = converter_config[dcc_pkg::DCC_SLEEP_BIT];
    case (min_pulse_width_o)
      2'b01: min_pulse_cycles_o = 8'(dcc_pkg::DCC_PW1_CYC);
      2'b10: min_pulse_cycles_o = 8'(dcc_pkg::DCC_PW2_CYC);
      2'b11: min_pulse_cycles_o = 8'(dcc_pkg::DCC_PW3_CYC);
      default: min_pulse_cycles_o = 8'h00;
    endcase
    case (output_voltage_select_o)
      3'b000: target_mv_o = 12'h708;
      3'b001: target_mv_o = 12'h76C;
      3'b010: target_mv_o = 12'h7D0;
      3'b011: target_mv_o = 12'h834;
      3'b100: target_mv_o = 12'h960;
      3'b101: target_mv_o = 12'hA8C;
      3'b110: target_mv_o = 12'hBB8;
      default: target_mv_o = 12'hCE4;
    endcase
  end

  // ==========================================================
  // converter clock
  logic div_tick;
  dcc_converter_clock_divider u_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .div_i(converter_config[dcc_pkg::DCC_CDIV_LSB +: 2]),
    .tick_o(div_tick)
  );
  // local oscillator is analog; divider ignored when it is selected
  assign converter_tick_o = converter_clock_source_o ? div_tick : 1'b0;

  // ==========================================================
  // switching cycle phase and ADC synchronisation (later revision behaviour)
  logic [7:0] phase;
  logic [7:0] next_phase;
  logic sar_clk;
  logic next_sar_clk;

  always_comb begin
    next_phase = phase;
    next_sar_clk = sar_clk;
    if (!sync_en) begin
      next_phase = 8'h00;
      next_sar_clk = ~sar_clk;
    end else if (div_tick) begin
      next_phase = (phase == 8'(dcc_pkg::DCC_PERIOD_CYC - 1)) ? 8'h00 : phase + 8'h01;
      next_sar_clk = ~sar_clk;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase <= 8'h00;
      sar_clk <= 1'b0;
    end else begin
      phase <= next_phase;
      sar_clk <= next_sar_clk;
    end
  end

  // is software's duty: the ADC's own SAR divider is zero while synced
  always_comb begin
    adc_sync_o = sync_en;
    adc_track_allow_o = !sync_en || (phase >= 8'(dcc_pkg::DCC_QUIET_START));
    adc_sar_clk_o = sar_clk;
    if (sync_en && !converter_config[dcc_pkg::DCC_AINV_BIT]) begin
      adc_sar_clk_o = ~sar_clk;
    end
  end

  // ==========================================================
  // assertions
  a_reset_values: assert property (@(posedge clk_i) srst_i |=>
    (converter_control == 8'h21) && (converter_config == 8'h00))
    else $error("reset values wrong");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (srst_i)
    converter_control[4] == 1'b0)
    else $error("reserved control bit set");
  a_ctl_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (sfr_wr_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'h97) |=>
    converter_control == ($past(sfr_wdata_i) & 8'hEF))
    else $error("control write lost");
  a_cfg_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (sfr_wr_i && sfr_page_i == 8'h00 && sfr_addr_i == 8'h96) |=>
    converter_config == ($past(sfr_wdata_i) & 8'h7F))
    else $error("config write lost");
  a_pulse_80: assert property (@(posedge clk_i) disable iff (srst_i)
    (min_pulse_width_o == 2'b11) |-> (min_pulse_cycles_o == 8'h14))
    else $error("80 ns width wrong");
  a_volt_map: assert property (@(posedge clk_i) disable iff (srst_i)
    (output_voltage_select_o == 3'b100) |-> (target_mv_o == 12'h960))
    else $error("voltage map wrong");
  a_free_track: assert property (@(posedge clk_i) disable iff (srst_i)
    !sync_en |-> adc_track_allow_o)
    else $error("tracking blocked while unsynced");
  a_quiet_track: assert property (@(posedge clk_i) disable iff (srst_i)
    (sync_en && phase < 8'h28) |-> !adc_track_allow_o)
    else $error("tracking in noisy interval");
  a_tick_off: assert property (@(posedge clk_i) disable iff (srst_i)
    !converter_clock_source_o |-> !converter_tick_o)
    else $error("tick while on local oscillator");
  a_sar_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    (sync_en && $past(sync_en) && !$past(div_tick)) |-> $stable(sar_clk))
    else $error("sar clock moved off switching tick");
  a_rd_unmapped: assert property (@(posedge clk_i) disable iff (srst_i)
    ($past(sfr_rd_i) && !$past(sfr_hit_o)) |-> (sfr_rdata_o == 8'h00))
    else $error("unmapped read not zero");
  a_sar_invert: assert property (@(posedge clk_i) disable iff (srst_i)
    (sync_en && $past(sync_en) && !$past(div_tick) &&
    $changed(converter_config[dcc_pkg::DCC_AINV_BIT])) |-> $changed(adc_sar_clk_o))
    else $error("sar clock ignored inversion bit");
  a_tick_div1: assert property (@(posedge clk_i) disable iff (srst_i)
    (converter_clock_source_o && converter_config[dcc_pkg::DCC_CDIV_LSB +: 2] == 2'b00)
    |-> converter_tick_o)
    else $error("divide-by-one tick missing");
endmodule

/* File: hdl/dcc_pkg.sv */
/*
  dcc_pkg: constants shared by the dc-dc converter control block.
  Assumes an 8-bit special-function-register port with page and address.
*/
package dcc_pkg;
  localparam logic [7:0] DCC_PAGE = 8'h00;
  localparam logic [7:0] DCC_CONFIG_ADDR = 8'h96;
  localparam logic [7:0] DCC_CONTROL_ADDR = 8'h97;
  localparam logic [7:0] DCC_CONTROL_RST = 8'h21;
  localparam logic [7:0] DCC_CONFIG_RST = 8'h00;
  // control register fields
  localparam int DCC_PULSE_LSB = 6;
  localparam int DCC_SWSZ_BIT = 5;
  localparam int DCC_RSVD_BIT = 4;
  localparam int DCC_SYNC_BIT = 3;
  localparam int DCC_VOUT_LSB = 0;
  // config register fields
  localparam int DCC_CDIV_LSB = 5;
  localparam int DCC_AINV_BIT = 4;
  localparam int DCC_CINV_BIT = 3;
  localparam int DCC_ILIM_BIT = 2;
  localparam int DCC_SLEEP_BIT = 1;
  localparam int DCC_CSRC_BIT = 0;
  // minimum pulse width, in ns, per code
  localparam int DCC_PW1_NS = 20;
  localparam int DCC_PW2_NS = 40;
  localparam int DCC_PW3_NS = 80;
  localparam int DCC_CLK_MHZ = 250;
  localparam int DCC_PW1_CYC = (DCC_PW1_NS * DCC_CLK_MHZ + 999) / 1000;
  localparam int DCC_PW2_CYC = (DCC_PW2_NS * DCC_CLK_MHZ + 999) / 1000;
  localparam int DCC_PW3_CYC = (DCC_PW3_NS * DCC_CLK_MHZ + 999) / 1000;
  // switching period, in system clocks, at divide-by-one
  localparam int DCC_PERIOD_CYC = 100;
  localparam int DCC_QUIET_START = 40;
endpackage

/* File: hdl/dcc_converter_clock_divider.sv */
/*
  dcc_converter_clock_divider: divides the system clock by 1, 2, 4 or 8 as a one-cycle enable.
  Assumes a single system clock and synchronous reset.
*/
`timescale 1ns/1ps
module dcc_converter_clock_divider (
  input wire logic clk_i, // system clock
  input wire logic srst_i, // sync reset
  input wire logic [1:0] div_i, // divide code
  output logic tick_o // one-cycle enable
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] lim;

  always_comb begin
    lim = 3'((4'h1 << div_i) - 4'h1);
    next_cnt = (cnt >= lim) ? 3'h0 : cnt + 3'h1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= 3'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick_o = (cnt >= lim);
endmodule

/* File: testbench/dcc_adc_model.sv */
/*
  dcc_adc_model: far-side counters standing in for the power stage and the ADC.
  Assumes the bench clears it with clr_i and reads the counts after a fixed window.
*/
`timescale 1ns/1ps
module dcc_adc_model (
  input wire logic clk_i, // system clock
  input wire logic clr_i, // clear counts
  input wire logic sync_i, // sync enabled
  input wire logic track_i, // tracking allowed
  input wire logic sar_clk_i, // SAR clock
  input wire logic tick_i, // converter tick
  input wire logic [4:0] sar_div_i, // adc_sar_clock_divider field
  output logic [15:0] track_cnt_o, // tracking cycles
  output logic [15:0] edge_cnt_o, // SAR clock toggles
  output logic [15:0] tick_cnt_o, // ticks seen
  output logic div_bad_o // sync with a nonzero divider
);
  logic sar_q;
  // the ADC only stays in step with the converter when its divider is zero
  assign div_bad_o = sync_i && (sar_div_i != 5'h00);
  always_ff @(posedge clk_i) begin
    sar_q <= sar_clk_i;
    if (clr_i) begin
      track_cnt_o <= 16'h0000;
      edge_cnt_o <= 16'h0000;
      tick_cnt_o <= 16'h0000;
    end else begin
      track_cnt_o <= track_cnt_o + 16'(track_i);
      edge_cnt_o <= edge_cnt_o + 16'(sar_clk_i ^ sar_q);
      tick_cnt_o <= tick_cnt_o + 16'(tick_i);
    end
  end
endmodule

/* File: testbench/tb_dcc_top.sv */
/*
  tb_dcc_top: self-checking bench for the converter register block.
  Assumes single clock, SFR strobes driven on the falling edge.
*/
`timescale 1ns/1ps
module tb_dcc_top;
  localparam logic [7:0] CTL = dcc_pkg::DCC_CONTROL_ADDR;
  localparam logic [7:0] CFG = dcc_pkg::DCC_CONFIG_ADDR;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] pg = 8'h00, ad = 8'h00, wd = 8'h00, rdata, pcyc;
  logic wr = 1'b0, rd = 1'b0, clr = 1'b0, hit, sw, src, tick, cinv, peak, slp, sync, trk, sar;
  logic [1:0] pw;
  logic [2:0] vs;
  logic [11:0] mv;
  logic [15:0] trk_n, edg_n, tck_n;
  logic bad;
  logic [4:0] sdiv = 5'h1F;
  int errors = 0;
  int tests_run = 0;
  always #2 clk_i = ~clk_i;
  dcc_top dut (.clk_i(clk_i), .srst_i(srst_i), .sfr_page_i(pg), .sfr_addr_i(ad),
    .sfr_wdata_i(wd), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .min_pulse_width_o(pw), .min_pulse_cycles_o(pcyc), .switch_size_select_o(sw),
    .output_voltage_select_o(vs), .target_mv_o(mv), .converter_clock_source_o(src),
    .converter_tick_o(tick), .converter_clock_invert_o(cinv), .peak_current_threshold_o(peak),
    .sleep_rail_connection_o(slp), .adc_sync_o(sync), .adc_track_allow_o(trk),
    .adc_sar_clk_o(sar));
  dcc_adc_model model (.clk_i(clk_i), .clr_i(clr), .sync_i(sync), .track_i(trk),
    .sar_clk_i(sar), .tick_i(tick), .sar_div_i(sdiv), .track_cnt_o(trk_n),
    .edge_cnt_o(edg_n), .tick_cnt_o(tck_n), .div_bad_o(bad));
  // ==========================================
  // helpers
  function automatic logic [11:0] exp_mv(input logic [2:0] c);
    logic [11:0] t [8] = '{12'h0708, 12'h076C, 12'h07D0, 12'h0834,
      12'h0960, 12'h0A8C, 12'h0BB8, 12'h0CE4};
    return t[c];
  endfunction
  function automatic logic [7:0] exp_cyc(input logic [1:0] c);
    logic [7:0] t [4] = '{8'h00, 8'h05, 8'h0A, 8'h14};
    return t[c];
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    pg = p;
    ad = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    pg = p;
    ad = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    d = rdata;
  endtask
  // counts are taken over exactly n rising edges after the clear
  task automatic measure(input int n);
    @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    repeat (n) @(negedge clk_i);
  endtask
  task automatic close_out();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    logic s0;
    int n;
    void'($urandom(71308));
    repeat (16) @(negedge clk_i);
    srst_i = 1'b0;
    rreg(8'h00, CTL, d);
    check("control reset", d, 8'h21);
    rreg(8'h00, CFG, d);
    check("config reset", d, 8'h00);
    check("reset mv", mv, 12'h076C);
    $display("reset test done");
    for (int i = 0; i < 16; i++) begin
      v = (i < 8) ? {i[1:0], ~i[0], 2'b10, i[2:0]} : (8'($urandom) & 8'hF7);
      wreg(8'h00, CTL, v);
      rreg(8'h00, CTL, d);
      check("control readback", d, v & 8'hEF);
      check("pulse code", pw, v[7:6]);
      check("pulse cycles", pcyc, exp_cyc(v[7:6]));
      check("switch size", sw, v[5]);
      check("voltage code", vs, v[2:0]);
      check("target mv", mv, exp_mv(v[2:0]));
    end
    wreg(8'h01, CTL, 8'h00);
    wreg(8'h00, 8'h98, 8'h00);
    rreg(8'h00, CTL, d);
    check("control kept", d, v & 8'hEF);
    check("control hit", hit, 1'b1);
    rreg(8'h01, CTL, d);
    check("other page", d, 8'h00);
    check("other page hit", hit, 1'b0);
    rreg(8'h00, 8'h95, d);
    check("unmapped", d, 8'h00);
    check("unmapped hit", hit, 1'b0);
    $display("control test done");
    for (int c = 0; c < 4; c++) begin
      v = {1'b1, c[1:0], 5'($urandom)} | 8'h01;
      wreg(8'h00, CFG, v);
      rreg(8'h00, CFG, d);
      check("config readback", d, v & 8'h7F);
      check("config hit", hit, 1'b1);
      check("clock source", src, 1'b1);
      check("sleep rail", slp, v[1]);
      check("peak limit", peak, v[2]);
      check("clock invert", cinv, v[3]);
      measure(64);
      check("ticks", tck_n, 16'h0040 >> c);
    end
    wreg(8'h00, CFG, 8'h00);
    measure(64);
    check("local osc ticks", tck_n, 16'h0000);
    check("clock source off", src, 1'b0);
    measure(100);
    check("free track", trk_n, 16'h0064);
    check("free sar", edg_n, 16'h0064);
    $display("config test done");
    wreg(8'h00, CFG, 8'h01);
    check("divider unsynced", bad, 1'b0);
    sdiv = 5'h00;
    wreg(8'h00, CTL, 8'h29);
    check("sync on", sync, 1'b1);
    check("divider zero", bad, 1'b0);
    measure(100);
    check("sync track", trk_n, 16'h003C);
    check("sync sar div1", edg_n, 16'h0064);
    wreg(8'h00, CFG, 8'h31);
    measure(200);
    check("sync track div2", trk_n, 16'h0078);
    check("sync sar div2", edg_n, 16'h0064);
    // land the inversion write between two divide-by-eight ticks
    wreg(8'h00, CFG, 8'h71);
    n = 0;
    while (tick !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check("tick seen", tick, 1'b1);
    if (tick === 1'b1) begin
      @(negedge clk_i);
      s0 = sar;
      wreg(8'h00, CFG, 8'h61);
      check("sar invert", sar, !s0);
    end
    $display("sync test done");
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    rreg(8'h00, CTL, d);
    check("control re-reset", d, 8'h21);
    rreg(8'h00, CFG, d);
    check("config re-reset", d, 8'h00);
    $display("second reset test done");
    close_out();
  end
endmodule
